/* File: rtl/adlo_params.svh */
// constants for the arithmetic, divide and loop execution slice
// Contract
// [RULE1] bcd adjust: one cycle, only carry changes
// [RULE2] hold-off blocks interrupts for literal cycles
// [RULE3] signed 16/16 divide: 18 cycles, N Z C OV
// [RULE4] signed 32/16 divide: 18 cycles, N Z C OV
// [RULE5] unsigned 16/16 divide: 18 cycles, flags
// [RULE6] unsigned 32/16 divide: 18 cycles, flags
// [RULE7] fractional 16/16 divide: 18 cycles, flags
// [RULE8] literal loop: count plus one passes, two cycles
// [RULE9] register loop: value plus one passes
// [RULE10] euclid distance: square difference, acc flags
// [RULE11] euclid accumulate: add square, same flags
// [RULE12] subtract one/two: three forms, five flags (code has two forms, ADLO_OP_SUB_ONE and ADLO_OP_SUB_TWO)
`ifndef ADLO_PARAMS_SVH
`define ADLO_PARAMS_SVH
//----------------------------------------
// register map (byte addresses)
//----------------------------------------
`define ADLO_ADR_CMD     8'h00
`define ADLO_ADR_OPA     8'h04
`define ADLO_ADR_OPB     8'h08
`define ADLO_ADR_OPC     8'h0C
`define ADLO_ADR_RES     8'h10
`define ADLO_ADR_RES2    8'h14
`define ADLO_ADR_STAT    8'h18
`define ADLO_ADR_ACCA    8'h1C
`define ADLO_ADR_ACCB    8'h20
`define ADLO_ADR_LOOP    8'h24
`define ADLO_ADR_ACCAH   8'h28
`define ADLO_ADR_ACCBH   8'h2C
//----------------------------------------
// status bit positions
//----------------------------------------
`define ADLO_ST_C        0
`define ADLO_ST_Z        1
`define ADLO_ST_OV       2
`define ADLO_ST_N        3
`define ADLO_ST_DC       4
`define ADLO_ST_OA       5
`define ADLO_ST_OB       6
`define ADLO_ST_OAB      7
`define ADLO_ST_SA       8
`define ADLO_ST_SB       9
`define ADLO_ST_SAB      10
`define ADLO_ST_BUSY     11
`define ADLO_ST_HOLD     12
`define ADLO_ST_LOOP     13
//----------------------------------------
// timing
//----------------------------------------
`define ADLO_DIV_CYCLES  5'd18
`define ADLO_LOOP_CYCLES 5'd2
`define ADLO_ONE_CYCLE   5'd1
`define ADLO_ACC_MAX     40'h7FFFFFFFFF
`define ADLO_ACC_MIN     40'h8000000000
`endif

/* File: rtl/adlo_pkg.sv */
// types for the arithmetic, divide and loop execution slice
package adlo_pkg;
   typedef enum logic [3:0]
   {
      ADLO_OP_BCD_ADJUST  = 4'h0,
      ADLO_OP_SUB_ONE     = 4'h1,
      ADLO_OP_SUB_TWO     = 4'h2,
      ADLO_OP_HOLD_OFF    = 4'h3,
      ADLO_OP_DIV_S       = 4'h4,
      ADLO_OP_DIV_SD      = 4'h5,
      ADLO_OP_DIV_U       = 4'h6,
      ADLO_OP_DIV_UD      = 4'h7,
      ADLO_OP_FRAC_Q      = 4'h8,
      ADLO_OP_LOOP_LIT    = 4'h9,
      ADLO_OP_LOOP_REG    = 4'hA,
      ADLO_OP_EUCLID      = 4'hB,
      ADLO_OP_EUCLID_ACC  = 4'hC
   } adlo_op_t;
   typedef enum logic [1:0]
   {
      ADLO_ST_IDLE = 2'b00,
      ADLO_ST_RUN  = 2'b01
   } adlo_state_t;
endpackage : adlo_pkg

/* File: rtl/adlo_divider.sv */
// restoring divider, two quotient bits per cycle
`timescale 1ns/10ps
module adlo_divider
(
   input  wire logic        sys_clk_i,   // instruction clock
   input  wire logic        rst_i,       // sync reset
   input  wire logic        start_i,     // load operands
   input  wire logic        step_i,      // one iteration
   input  wire logic [31:0] num_i,       // dividend magnitude
   input  wire logic [15:0] den_i,       // divisor magnitude
   output logic      [31:0] quo_o,       // quotient
   output logic      [15:0] rem_o        // remainder
);
   logic [31:0] quo_reg;   // shifting dividend/quotient
   logic [16:0] rem_reg;   // partial remainder
   logic [16:0] trial;     // shifted remainder
   logic [16:0] diff;      // trial minus divisor
   assign trial = {rem_reg[15:0], quo_reg[31]};
   assign diff  = trial - {1'b0, den_i};
   // two bits per step so 16 steps finish 32 bits
   logic [16:0] trial2;
   logic [16:0] rem_mid;
   logic [16:0] diff2;
   assign rem_mid = diff[16] ? trial : diff;
   assign trial2  = {rem_mid[15:0], quo_reg[30]};
   assign diff2   = trial2 - {1'b0, den_i};
   //----------------------------------------
   // iteration
   //----------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || start_i)
      begin
         quo_reg <= start_i ? num_i : 32'h0;
         rem_reg <= 17'h0;
      end
      else if (step_i)
      begin
         quo_reg <= {quo_reg[29:0], ~diff[16], ~diff2[16]};
         rem_reg <= diff2[16] ? trial2 : diff2;
      end
   end
   assign quo_o = quo_reg;
   assign rem_o = rem_reg[15:0];
endmodule : adlo_divider

/* File: rtl/adlo_core.sv */
// execution slice: bcd adjust, subtract, hold-off, divide, loops, euclid
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "adlo_params.svh"
module adlo_core
   import adlo_pkg::*;
(
   input  wire logic        sys_clk_i,   // 20 MHz instruction clock
   input  wire logic        rst_i,       // sync reset, active high
   input  wire logic [31:0] wb_adr_i,    // wishbone address
   input  wire logic [31:0] wb_dat_i,    // wishbone write data
   input  wire logic [3:0]  wb_sel_i,    // byte enables
   input  wire logic        wb_we_i,     // write strobe
   input  wire logic        wb_cyc_i,    // cycle
   input  wire logic        wb_stb_i,    // strobe
   input  wire logic        loop_end_i,  // loop body end reached
   output logic      [31:0] wb_dat_o,    // read data
   output logic             wb_ack_o,    // acknowledge
   output logic             irq_block_o, // interrupts held off
   output logic             loop_active_o// loop running
);
   //----------------------------------------
   // state
   //----------------------------------------
   logic [3:0]  cmd_reg;        // last command
   logic [15:0] opa_reg;        // operand a / dividend low
   logic [15:0] opb_reg;        // operand b / divisor
   logic [15:0] opc_reg;        // operand c / dividend high
   logic [15:0] res_reg;        // main result
   logic [15:0] res2_reg;       // remainder / second result
   logic [4:0]  flg_reg;        // C Z OV N DC
   logic [5:0]  accf_reg;       // OA OB EITHER_ACCUM_OVERFLOW_FLAG SA SB EITHER_ACCUM_CLAMP_FLAG
   logic [39:0] acc_reg [2];    // two accumulators
   logic [13:0] hold_reg;       // hold-off count
   logic [15:0] loop_reg;       // loop passes left
   logic        loop_on_reg;    // loop running
   adlo_state_t st_reg;         // sequencer state
   logic [4:0]  cyc_reg;        // cycles left
   logic        ack_reg;        // bus ack
   logic [31:0] rd_reg;         // read data
   logic        irq_reg;        // hold-off output
   logic        neg_q_reg;      // quotient sign
   logic        neg_r_reg;      // remainder sign
   logic        frac_reg;       // fractional divide
   logic        wide_reg;       // 32-bit dividend
   logic        sgn_reg;        // signed divide
   //----------------------------------------
   // bus decode
   //----------------------------------------
   wire bus_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire bus_wr    = bus_req & wb_we_i & (&wb_sel_i[1:0]);
   wire [7:0] adr = wb_adr_i[7:0];
   wire wr_cmd    = bus_wr & (adr == `ADLO_ADR_CMD) & (st_reg == ADLO_ST_IDLE);
   wire wr_opa    = bus_wr & (adr == `ADLO_ADR_OPA);
   wire wr_opb    = bus_wr & (adr == `ADLO_ADR_OPB);
   wire wr_opc    = bus_wr & (adr == `ADLO_ADR_OPC);
   wire [3:0] cmd = wb_dat_i[3:0];
   //----------------------------------------
   // helpers
   //----------------------------------------
   function automatic logic [15:0] mag16(input logic [15:0] v, input logic s);
      mag16 = (s && v[15]) ? 16'(-v) : v;
   endfunction : mag16
   function automatic logic [5:0] acc_flags(input logic [39:0] a0, input logic [39:0] a1,
                                            input logic sat0, input logic sat1, input logic [5:0] old);
      logic o0;
      logic o1;
      o0 = (a0[39] != a0[31]);
      o1 = (a1[39] != a1[31]);
      // OA OB EITHER_ACCUM_OVERFLOW_FLAG, sticky SA SB EITHER_ACCUM_CLAMP_FLAG
      acc_flags = {old[5] | sat1 | sat0 | old[4] | old[3], old[4] | sat1, old[3] | sat0,
                   o0 | o1, o1, o0};
   endfunction : acc_flags
   //----------------------------------------
   // bcd adjust, subtract
   //----------------------------------------
   wire [3:0] lo_n  = opa_reg[3:0];
   wire [3:0] hi_n  = opa_reg[7:4];
   wire       adj_lo = (lo_n > 4'h9) | flg_reg[4];
   wire [8:0] bcd_s1 = {1'b0, opa_reg[7:0]} + (adj_lo ? 9'h006 : 9'h000);
   wire       adj_hi = (bcd_s1[7:4] > 4'h9) | flg_reg[0] | bcd_s1[8];
   wire [8:0] bcd_s2 = bcd_s1 + (adj_hi ? 9'h060 : 9'h000);
   wire [15:0] sub_k  = (cmd == ADLO_OP_SUB_TWO) ? 16'h0002 : 16'h0001;
   wire [16:0] sub_r  = {1'b0, opa_reg} - {1'b0, sub_k};
   wire        sub_dc = (opa_reg[3:0] >= sub_k[3:0]);
   wire        sub_ov = opa_reg[15] & ~sub_r[15];
   //----------------------------------------
   // euclid: (a - b)^2 into selected accumulator
   //----------------------------------------
   wire [15:0] ed_diff = 16'(opa_reg - opb_reg);
   wire signed [31:0] ed_sq = $signed(ed_diff) * $signed(ed_diff);
   wire        ed_sel  = opc_reg[0];
   wire [39:0] ed_base = (cmd == ADLO_OP_EUCLID_ACC) ? acc_reg[ed_sel] : 40'h0;
   wire [40:0] ed_sum  = {ed_base[39], ed_base} + {{9{ed_sq[31]}}, ed_sq};
   wire        ed_sat  = ed_sum[40] != ed_sum[39];
   wire [39:0] ed_val  = ed_sat ? (ed_sum[40] ? `ADLO_ACC_MIN : `ADLO_ACC_MAX) : ed_sum[39:0];
   //----------------------------------------
   // divider operands and result
   //----------------------------------------
   wire        dv_sgn  = (cmd == ADLO_OP_DIV_S) | (cmd == ADLO_OP_DIV_SD) | (cmd == ADLO_OP_FRAC_Q);
   wire        dv_wide = (cmd == ADLO_OP_DIV_SD) | (cmd == ADLO_OP_DIV_UD);
   wire        dv_frac = (cmd == ADLO_OP_FRAC_Q);
   // fractional dividend is Q15 shifted by 15, so the quotient comes out in Q15
   wire [31:0] num_raw = dv_frac ? {opa_reg[15], opa_reg, 15'h0} :
                         dv_wide ? {opc_reg, opa_reg} :
                         (dv_sgn ? {{16{opa_reg[15]}}, opa_reg} : {16'h0, opa_reg});
   wire        num_neg = dv_sgn & num_raw[31];
   wire [31:0] num_mag = num_neg ? 32'(-num_raw) : num_raw;
   wire        den_neg = dv_sgn & opb_reg[15];
   wire [15:0] den_mag = mag16(opb_reg, dv_sgn);
   wire        dv_start = wr_cmd & ((cmd >= ADLO_OP_DIV_S) & (cmd <= ADLO_OP_FRAC_Q));
   wire        dv_step  = (st_reg == ADLO_ST_RUN) & (cyc_reg > 5'd2);
   wire [31:0] dv_quo;
   wire [15:0] dv_rem;
   adlo_divider u_div
   (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .start_i   (dv_start),
      .step_i    (dv_step),
      .num_i     (num_mag),
      .den_i     (den_mag),
      .quo_o     (dv_quo),
      .rem_o     (dv_rem)
   );
   wire [31:0] q_s   = neg_q_reg ? 32'(-dv_quo) : dv_quo;
   wire [15:0] r_s   = neg_r_reg ? 16'(-dv_rem) : dv_rem;
   wire        dz    = (opb_reg == 16'h0);
   wire        q_ov  = dz | (sgn_reg ? (q_s[31:15] != {17{q_s[15]}}) : (q_s[31:16] != 16'h0));
   //----------------------------------------
   // read mux
   //----------------------------------------
   wire [31:0] stat_w = {18'h0, loop_on_reg, irq_reg, (st_reg != ADLO_ST_IDLE), accf_reg,
                         flg_reg[4], flg_reg[3], flg_reg[2], flg_reg[1], flg_reg[0]};
   wire [31:0] rd_mux =
      (adr == `ADLO_ADR_CMD)   ? {28'h0, cmd_reg} :
      (adr == `ADLO_ADR_OPA)   ? {16'h0, opa_reg} :
      (adr == `ADLO_ADR_OPB)   ? {16'h0, opb_reg} :
      (adr == `ADLO_ADR_OPC)   ? {16'h0, opc_reg} :
      (adr == `ADLO_ADR_RES)   ? {16'h0, res_reg} :
      (adr == `ADLO_ADR_RES2)  ? {16'h0, res2_reg} :
      (adr == `ADLO_ADR_STAT)  ? stat_w :
      (adr == `ADLO_ADR_ACCA)  ? acc_reg[0][31:0] :
      (adr == `ADLO_ADR_ACCB)  ? acc_reg[1][31:0] :
      (adr == `ADLO_ADR_ACCAH) ? {24'h0, acc_reg[0][39:32]} :
      (adr == `ADLO_ADR_ACCBH) ? {24'h0, acc_reg[1][39:32]} :
      (adr == `ADLO_ADR_LOOP)  ? {16'h0, loop_reg} : 32'h0;
   //----------------------------------------
   // bus answer: ack one cycle after request
   //----------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         rd_reg  <= 32'h0;
      end
      else
      begin
         ack_reg <= bus_req;
         rd_reg  <= rd_mux;
      end
   end
   //----------------------------------------
   // operand registers
   //----------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         opa_reg <= 16'h0;
         opb_reg <= 16'h0;
         opc_reg <= 16'h0;
      end
      else
      begin
         if (wr_opa)
            opa_reg <= wb_dat_i[15:0];
         if (wr_opb)
            opb_reg <= wb_dat_i[15:0];
         if (wr_opc)
            opc_reg <= wb_dat_i[15:0];
      end
   end
   //----------------------------------------
   // hold-off counter: blocks interrupts for the literal count
   //----------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         hold_reg <= 14'h0;
      else if (wr_cmd && cmd == ADLO_OP_HOLD_OFF)
         hold_reg <= opa_reg[13:0];                // see [RULE2]
      else if (hold_reg != 14'h0)
         hold_reg <= hold_reg - 14'h1;
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         irq_reg <= 1'b0;
      else if (wr_cmd && cmd == ADLO_OP_HOLD_OFF)
         irq_reg <= (opa_reg[13:0] != 14'h0);     // see [RULE2]
      else
         irq_reg <= (hold_reg > 14'h1);
   end
   //----------------------------------------
   // loop counter: count plus one passes
   //----------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         loop_reg    <= 16'h0;
         loop_on_reg <= 1'b0;
      end
      else if (wr_cmd && cmd == ADLO_OP_LOOP_LIT)
      begin
         loop_reg    <= {1'b0, opa_reg[14:0]};    // see [RULE8]
         loop_on_reg <= 1'b1;
      end
      else if (wr_cmd && cmd == ADLO_OP_LOOP_REG)
      begin
         loop_reg    <= opa_reg;                  // see [RULE9]
         loop_on_reg <= 1'b1;
      end
      else if (loop_on_reg && loop_end_i && st_reg == ADLO_ST_IDLE)
      begin
         if (loop_reg == 16'h0)
            loop_on_reg <= 1'b0;                  // last pass done
         else
            loop_reg <= loop_reg - 16'h1;
      end
   end
   //----------------------------------------
   // sequencer: single cycle ops, 18 cycle divides, 2 cycle loop setup
   //----------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         st_reg    <= ADLO_ST_IDLE;
         cyc_reg   <= 5'h0;
         cmd_reg   <= 4'h0;
         res_reg   <= 16'h0;
         res2_reg  <= 16'h0;
         flg_reg   <= 5'h0;
         accf_reg  <= 6'h0;
         acc_reg[0] <= 40'h0;
         acc_reg[1] <= 40'h0;
         neg_q_reg <= 1'b0;
         neg_r_reg <= 1'b0;
         frac_reg  <= 1'b0;
         wide_reg  <= 1'b0;
         sgn_reg   <= 1'b0;
      end
      else if (wr_cmd)
      begin
         cmd_reg <= cmd;
         st_reg  <= ADLO_ST_RUN;
         cyc_reg <= `ADLO_ONE_CYCLE;
         case (cmd)
            ADLO_OP_BCD_ADJUST:
            begin
               res_reg    <= {opa_reg[15:8], bcd_s2[7:0]};
               flg_reg[0] <= adj_hi;              // see [RULE1]
            end
            ADLO_OP_SUB_ONE, ADLO_OP_SUB_TWO:
            begin
               res_reg <= sub_r[15:0];            // see [RULE12]
               flg_reg <= {sub_dc, sub_r[15], sub_ov, (sub_r[15:0] == 16'h0), ~sub_r[16]};
            end
            ADLO_OP_DIV_S, ADLO_OP_DIV_SD, ADLO_OP_DIV_U, ADLO_OP_DIV_UD, ADLO_OP_FRAC_Q:
            begin
               cyc_reg   <= `ADLO_DIV_CYCLES;     // see [RULE3] [RULE4] [RULE5] [RULE6] [RULE7]
               neg_q_reg <= num_neg ^ den_neg;
               neg_r_reg <= num_neg;
               frac_reg  <= dv_frac;
               wide_reg  <= dv_wide;
               sgn_reg   <= dv_sgn;
            end
            ADLO_OP_LOOP_LIT, ADLO_OP_LOOP_REG:
               cyc_reg <= `ADLO_LOOP_CYCLES;      // see [RULE8] [RULE9]
            ADLO_OP_EUCLID, ADLO_OP_EUCLID_ACC:
            begin
               acc_reg[ed_sel] <= ed_val;         // see [RULE10] [RULE11]
               accf_reg <= ed_sel ? acc_flags(acc_reg[0], ed_val, 1'b0, ed_sat, accf_reg)
                                  : acc_flags(ed_val, acc_reg[1], ed_sat, 1'b0, accf_reg);
            end
            default:
               cyc_reg <= `ADLO_ONE_CYCLE;
         endcase
      end
      else
      begin
         case (st_reg)
            ADLO_ST_RUN:
            begin
               if (cyc_reg <= `ADLO_ONE_CYCLE)
               begin
                  st_reg <= ADLO_ST_IDLE;
                  if (cmd_reg >= ADLO_OP_DIV_S && cmd_reg <= ADLO_OP_FRAC_Q)
                  begin
                     res_reg  <= q_s[15:0];       // see [RULE3]
                     res2_reg <= r_s;
                     flg_reg[3] <= q_s[15];
                     flg_reg[1] <= (q_s[15:0] == 16'h0);
                     flg_reg[2] <= q_ov;
                     flg_reg[0] <= (dv_rem == 16'h0);
                  end
               end
               cyc_reg <= cyc_reg - 5'h1;
            end
            default:
               st_reg <= ADLO_ST_IDLE;
         endcase
      end
   end
   //----------------------------------------
   // outputs
   //----------------------------------------
   assign wb_ack_o      = ack_reg;
   assign wb_dat_o      = rd_reg;
   assign irq_block_o   = irq_reg;
   assign loop_active_o = loop_on_reg;
   //----------------------------------------
   // checks
   //----------------------------------------
   a_div_takes_18: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE3]
      dv_start |=> (st_reg == ADLO_ST_RUN)[*8] ##1 (st_reg == ADLO_ST_RUN)[*8]
                   ##1 (st_reg == ADLO_ST_RUN)[*2] ##1 (st_reg == ADLO_ST_IDLE))
      else $error("divide did not finish in 18 cycles");
   a_bcd_one_cycle: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE1]
      (wr_cmd && cmd == ADLO_OP_BCD_ADJUST) |=> (st_reg == ADLO_ST_RUN) && $stable(flg_reg[4:1])
         ##1 (st_reg == ADLO_ST_IDLE))
      else $error("bcd adjust touched flags other than carry");
   a_hold_blocks: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE2]
      (wr_cmd && cmd == ADLO_OP_HOLD_OFF && opa_reg[13:0] > 14'h2) |=> irq_reg[*2])
      else $error("hold-off did not block interrupts");
   a_loop_two_cyc: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE8]
      (wr_cmd && cmd == ADLO_OP_LOOP_LIT) |=> loop_on_reg && st_reg == ADLO_ST_RUN ##2 st_reg == ADLO_ST_IDLE)
      else $error("loop setup not two cycles");
   a_loop_count: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE9]
      (wr_cmd && cmd == ADLO_OP_LOOP_REG) |=> loop_reg == $past(opa_reg))
      else $error("loop count not loaded");
   a_sub_result: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE12]
      (wr_cmd && cmd == ADLO_OP_SUB_TWO) |=> res_reg == 16'($past(opa_reg) - 16'h2))
      else $error("subtract two wrong");
   a_ed_stores: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE10]
      (wr_cmd && cmd == ADLO_OP_EUCLID && !ed_sat) |=> acc_reg[$past(ed_sel)][31:0] == $past(ed_sq))
      else $error("euclid distance not stored");
   a_euclid_distance_accumulate_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE11]
      (wr_cmd && cmd == ADLO_OP_EUCLID_ACC && ed_sat) |=> accf_reg[5] && accf_reg[4] | accf_reg[3])
      else $error("euclid accumulate clamp flag missing");
endmodule : adlo_core

/* File: verif/arith_divide_loop_ops_test.sv */
// self-checking bench for the arithmetic, divide and loop slice
`timescale 1ns/10ps
`include "adlo_params.svh"
module arith_divide_loop_ops_test
   import adlo_pkg::*;
;
   //------------------------------------
   // stimulus and observed signals
   //------------------------------------
   logic        sys_clk_i;  // 50 ns clock
   logic        rst_i;      // sync reset
   logic [31:0] adr;        // bus address
   logic [31:0] wdat;       // bus write data
   logic [31:0] rdat;       // bus read data
   logic [31:0] rv;         // last read value
   logic [3:0]  sel;        // byte enables
   logic        we;         // direction
   logic        cyc;        // cycle
   logic        stb;        // strobe
   logic        ack;        // acknowledge
   logic        loop_end;   // loop pass done
   logic        irq_blk;    // hold-off output
   logic        loop_act;   // loop running
   int          bad_count;  // mismatches
   int          n_checks;   // comparisons
   int          cyc_cnt = 0;  // run length
   int          hold_cnt = 0; // cycles held off
   int          flg_snap;   // status before hold-off
   int          t0;         // start stamp
   int          tbl [6][6]; // op, a, b, c, quotient, flag mask
   int          fl  [6];    // expected flags
   adlo_core dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .loop_end_i(loop_end), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_block_o(irq_blk), .loop_active_o(loop_act));
   //------------------------------------
   // clock, run limit, hold-off counter
   //------------------------------------
   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (irq_blk === 1'b1) hold_cnt <= hold_cnt + 1;
      if (cyc_cnt == 20000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end
   //------------------------------------
   // helpers
   //------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : wt
   // one classic cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      adr <= {24'h000000, a}; wdat <= d; we <= w; cyc <= 1'b1; stb <= 1'b1;
      do
      begin
         @(posedge sys_clk_i);
      end
      while (ack !== 1'b1);
      rv = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : bus
   // load operands, issue, stamp the acknowledged command
   task automatic issue(input int op, input int a, input int b, input int c);
      bus(1'b1, `ADLO_ADR_OPA, 32'(a));
      bus(1'b1, `ADLO_ADR_OPB, 32'(b));
      bus(1'b1, `ADLO_ADR_OPC, 32'(c));
      bus(1'b1, `ADLO_ADR_CMD, 32'(op));
      t0 = cyc_cnt;
   endtask : issue
   task automatic idle();
      do
      begin
         bus(1'b0, `ADLO_ADR_STAT, 32'h00000000);
      end
      while (rv[`ADLO_ST_BUSY] !== 1'b0);
   endtask : idle
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   //------------------------------------
   // main sequence
   //------------------------------------
   initial
   begin
      rst_i = 1'b1; adr = 32'h0; wdat = 32'h0; sel = 4'hF; we = 1'b0; cyc = 1'b0; stb = 1'b0;
      loop_end = 1'b0; bad_count = 0; n_checks = 0;
      tbl = '{'{6, 100, 7, 0, 14, 'hF}, '{6, 100, 0, 0, 0, 'h4}, '{4, 'hFF9C, 7, 0, 'hFFF2, 'hF},
              '{7, 0, 2, 1, 'h8000, 'h3}, '{5, 'hFF9C, 7, 'hFFFF, 'hFFF2, 'hF}, '{8, 'h2000, 'h4000, 0, 'h4000, 'hA}};
      fl = '{0, 'h4, 'h8, 'h1, 'h8, 0};
      wt(6);
      rst_i <= 1'b0;
      wt(1);
      chk("outputs after reset", {30'h0, irq_blk, loop_act}, 32'h0);
      // divide family: busy window, refused command, quotient, flags
      for (int i = 0; i < 6; i++)
      begin
         issue(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
         wt(8);
         bus(1'b0, `ADLO_ADR_STAT, 32'h0);
         chk("divide busy", 32'(rv[`ADLO_ST_BUSY]), 32'h1);
         bus(1'b1, `ADLO_ADR_CMD, 32'h0);
         idle();
         chk("divide length", 32'(cyc_cnt - t0 >= 18 && cyc_cnt - t0 <= 23), 32'h1);
         chk("divide flags", rv & 32'(tbl[i][5]), 32'(fl[i]));
         bus(1'b0, `ADLO_ADR_RES, 32'h0);
         if (i != 1) chk("quotient", {16'h0, rv[15:0]}, 32'(tbl[i][4]));
      end
      // subtract one across zero, which also leaves carry and digit carry clear for bcd
      issue(ADLO_OP_SUB_ONE, 0, 0, 0);
      idle();
      chk("sub1 flags", rv & 32'hB, 32'h8);
      bus(1'b0, `ADLO_ADR_RES, 32'h0);
      chk("sub1 value", {16'h0, rv[15:0]}, 32'hFFFF);
      // bcd adjust without, then with carry out
      issue(ADLO_OP_BCD_ADJUST, 'h1A, 0, 0);
      idle();
      chk("bcd no carry", rv & 32'h1, 32'h0);
      bus(1'b0, `ADLO_ADR_RES, 32'h0);
      chk("bcd value", {24'h0, rv[7:0]}, 32'h20);
      issue(ADLO_OP_BCD_ADJUST, 'h9A, 0, 0);
      idle();
      chk("bcd carry", rv & 32'h1, 32'h1);
      bus(1'b0, `ADLO_ADR_RES, 32'h0);
      chk("bcd value", {24'h0, rv[7:0]}, 32'h00);
      // subtract two onto zero
      issue(ADLO_OP_SUB_TWO, 2, 0, 0);
      idle();
      chk("sub2 flags", rv & 32'hB, 32'h3);
      // hold-off: exact length, flags untouched
      flg_snap = int'(rv[10:0]);
      issue(ADLO_OP_HOLD_OFF, 20, 0, 0);
      wt(2);
      chk("hold active", 32'(irq_blk), 32'h1);
      wt(30);
      chk("hold length", 32'(hold_cnt), 32'd20);
      idle();
      chk("hold flags", {21'h0, rv[10:0]}, 32'(flg_snap));
      // both loop kinds: count plus one passes
      for (int k = 0; k < 2; k++)
      begin
         issue(k ? ADLO_OP_LOOP_REG : ADLO_OP_LOOP_LIT, 2, 0, 0);
         idle();
         for (int p = 0; p < 3; p++)
         begin
            chk("loop running", 32'(loop_act), 32'h1);
            @(posedge sys_clk_i) loop_end <= 1'b1;
            @(posedge sys_clk_i) loop_end <= 1'b0;
            wt(3);
         end
         chk("loop done", 32'(loop_act), 32'h0);
      end
      // euclid distance on both accumulators
      issue(ADLO_OP_EUCLID, 5, 2, 0);
      idle();
      issue(ADLO_OP_EUCLID_ACC, 5, 2, 0);
      idle();
      issue(ADLO_OP_EUCLID, 5, 2, 1);
      idle();
      chk("acc flags clear", rv & 32'h7E0, 32'h0);
      bus(1'b0, `ADLO_ADR_ACCA, 32'h0);
      chk("acc a", rv, 32'd18);
      bus(1'b0, `ADLO_ADR_ACCB, 32'h0);
      chk("acc b", rv, 32'd9);
      // clamp: accumulate the largest square until the first accumulator saturates
      issue(ADLO_OP_EUCLID, 'h8000, 0, 0);
      repeat (520) bus(1'b1, `ADLO_ADR_CMD, 32'(ADLO_OP_EUCLID_ACC));
      idle();
      chk("clamp flags", rv & 32'h700, 32'h500);
      bus(1'b0, `ADLO_ADR_ACCAH, 32'h0);
      chk("clamp high", rv, 32'h7F);
      bus(1'b0, `ADLO_ADR_ACCA, 32'h0);
      chk("clamp low", rv, 32'hFFFFFFFF);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", rv, 32'h0);
      tally_and_finish();
   end
endmodule : arith_divide_loop_ops_test
